//--- can_acceptance_filter_control.sv
// How it works
// - enable bit switches each of filters 24,25,28..31 on or off
// - two-bit code picks one of four masks
// - five-bit code picks target receive FIFO 0-31
// - selectors writable only while filter disabled
// - filters 31..28 fill register 7 top down
// - filters 25,24 in register 6 bytes 1,0
// - system error clears only on off-on cycle
// - module-active stays set while shutdown finishes
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module can_acceptance_filter_control
   import can_filter_pkg::*;
#(
   parameter int NUM_FILTERS = 8,
   parameter int SHUTDOWN_LEN = SHUTDOWN_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire rx_ident_t rx_i,
   input wire logic sys_err_i,
   output accept_t accept_o,
   output logic irq_o
);

   initial begin
      if (NUM_FILTERS != 8) $error("filter block serves exactly filters 24..31");
      if (SHUTDOWN_LEN < 1 || SHUTDOWN_LEN > 15) $error("shutdown length out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire wr_fc6 = wr_i && addr_i == IDX_FILTER_CONTROL_6;
   wire wr_fc7 = wr_i && addr_i == IDX_FILTER_CONTROL_7;
   wire wr_mctl = wr_i && addr_i == IDX_MODULE_CONTROL;
   wire wr_stat = wr_i && addr_i == IDX_INT_STATUS;
   wire wr_imask = wr_i && addr_i == IDX_INT_MASK;
   wire wr_mask = wr_i && addr_i[3:2] == IDX_MASK_BASE[3:2];
   wire wr_id = wr_i && addr_i[3:2] == IDX_ID_BASE[3:2];

   ////////////////////////////////////////////////////////////////////////////
   // filter configuration, one byte per filter
   filter_cfg_t cfg_q [8];
   logic [28:0] mask_q [4];
   logic [28:0] id_q [8];
   logic [7:0] cfg_wr;
   logic [7:0] cfg_wbyte [8];

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_flt
         // filters 24,25 live in register 6 bytes 0,1; 28..31 in register 7
         localparam int BYTE = g % 4;
         // ids 24,25 sit at the first two id slots, 28,29 at the next two
         localparam logic [3:0] ID_IDX = (g < 2) ? 4'(IDX_ID_BASE + g) : 4'(IDX_ID_BASE + g - 2);
         // ids of 26,27,30,31 have no slot, so they stay at reset
         localparam bit ID_WRITABLE = (g < 2) || (g == 4) || (g == 5);
         if (g < 2) begin : g_r6
            assign cfg_wr[g] = wr_fc6;
         end else if (g >= 4) begin : g_r7
            assign cfg_wr[g] = wr_fc7;
         end else begin : g_none
            // filters 26,27 belong to another register
            assign cfg_wr[g] = 1'b0;
         end
         assign cfg_wbyte[g] = wdata_i[BYTE*8 +: 8];

         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               cfg_q[g] <= filter_cfg_t'(FILTER_CONTROL_RESET[7:0]);
            end else if (cfg_wr[g]) begin
               cfg_q[g].enable <= cfg_wbyte[g][FLD_ENABLE];
               // a live filter keeps its selectors; disable first
               if (!cfg_q[g].enable) begin
                  cfg_q[g].mask_select <= cfg_wbyte[g][FLD_MASK_SELECT_LO +: 2];
                  cfg_q[g].fifo_select <= cfg_wbyte[g][FLD_FIFO_SELECT_LO +: 5];
               end
            end
         end

         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               id_q[g] <= ID_RESET;
            end else if (ID_WRITABLE && wr_id && addr_i == ID_IDX) begin
               id_q[g] <= wdata_i[28:0];
            end
         end
      end
      for (g = 0; g < 4; g++) begin : g_mask
         localparam logic [1:0] MSK_IDX = 2'(g);
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               mask_q[g] <= ID_RESET;
            end else if (wr_mask && addr_i[1:0] == MSK_IDX) begin
               mask_q[g] <= wdata_i[28:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // module on/off and shutdown drain
   run_state_t state_q, state_d;
   logic [3:0] drain_q;
   logic on_q;
   wire on_d = wr_mctl ? wdata_i[MCTL_ON_BIT] : on_q;
   wire module_active = state_q != ST_OFF;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: if (on_q) state_d = ST_ON;
         ST_ON: if (!on_q) state_d = ST_DRAIN;
         // stays busy a few cycles so software polls before reuse
         ST_DRAIN: if (drain_q == 4'h1) state_d = ST_OFF;
         default: state_d = ST_OFF;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         on_q <= 1'b0;
         state_q <= ST_OFF;
         drain_q <= 4'h0;
      end else begin
         on_q <= on_d;
         state_q <= state_d;
         drain_q <= (state_q == ST_ON && !on_q) ? 4'(SHUTDOWN_LEN) :
                    (drain_q != 4'h0 ? drain_q - 4'h1 : 4'h0);
      end
   end

   // turning on after off is the only clear of the system error
   wire off_on_edge = wr_mctl && wdata_i[MCTL_ON_BIT] && !on_q;

   ////////////////////////////////////////////////////////////////////////////
   // acceptance: lowest enabled matching filter wins
   logic [2:0] hit_idx;
   logic hit_any;
   always_comb begin
      hit_idx = 3'h0;
      hit_any = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (i != 2 && i != 3 && cfg_q[i].enable &&
             ((rx_i.ident ^ id_q[i]) & mask_q[cfg_q[i].mask_select]) == 29'h0) begin
            hit_idx = 3'(i);
            hit_any = 1'b1;
         end
      end
   end
   wire do_accept = rx_i.valid && on_q && hit_any;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         accept_o <= '0;
      end else begin
         accept_o.valid <= do_accept;
         accept_o.filter <= hit_idx;
         accept_o.fifo <= cfg_q[hit_idx].fifo_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: sticky status, match bit write-one-to-clear, set wins
   logic [INT_NUM-1:0] stat_q, imask_q;
   logic [INT_NUM-1:0] stat_set, stat_clr;
   assign stat_set = {do_accept, sys_err_i && on_q};
   // system error ignores write-one-to-clear
   assign stat_clr = {wr_stat && wdata_i[INT_MATCH_BIT], off_on_edge};

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stat_q <= '0;
         imask_q <= '0;
         irq_o <= 1'b0;
      end else begin
         stat_q <= stat_set | (stat_q & ~stat_clr);
         if (wr_imask) imask_q <= wdata_i[INT_NUM-1:0];
         irq_o <= |((stat_set | (stat_q & ~stat_clr)) &
                    (wr_imask ? wdata_i[INT_NUM-1:0] : imask_q));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path, data one cycle after strobe
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (addr_i)
         IDX_FILTER_CONTROL_6: rd_mux = {16'h0000, cfg_q[1], cfg_q[0]};
         IDX_FILTER_CONTROL_7: rd_mux = {cfg_q[7], cfg_q[6], cfg_q[5], cfg_q[4]};
         IDX_MODULE_CONTROL: begin
            rd_mux[MCTL_ON_BIT] = on_q;
            rd_mux[MCTL_ACTIVE_BIT] = module_active;
         end
         IDX_INT_STATUS: rd_mux[INT_NUM-1:0] = stat_q;
         IDX_INT_MASK: rd_mux[INT_NUM-1:0] = imask_q;
         4'h8, 4'h9, 4'hA, 4'hB: rd_mux[28:0] = mask_q[addr_i[1:0]];
         4'hC, 4'hD: rd_mux[28:0] = id_q[{2'b00, addr_i[0]}];
         4'hE, 4'hF: rd_mux[28:0] = id_q[{2'b10, addr_i[0]}];
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else begin
         rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_locked_select: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cfg_q[4].enable |=> $stable(cfg_q[4].fifo_select) && $stable(cfg_q[4].mask_select))
      else $error("selector changed while filter enabled");
   a_enable_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc7 |=> cfg_q[7].enable == $past(wdata_i[31]))
      else $error("filter 31 enable not written");
   a_fc6_layout: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc6 && !cfg_q[1].enable |=> cfg_q[1].fifo_select == $past(wdata_i[12:8]))
      else $error("filter 25 fifo field misplaced");
   a_mask_select_layout: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc6 && !cfg_q[0].enable |=> cfg_q[0].mask_select == $past(wdata_i[6:5]))
      else $error("filter 24 mask field misplaced");
   a_syserr_sticky: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      stat_q[INT_SYSERR_BIT] && !off_on_edge |=> stat_q[INT_SYSERR_BIT])
      else $error("system error cleared without off-on");
   sequence s_switch_off;
      state_q == ST_ON && !on_q;
   endsequence
   a_drain_busy: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      s_switch_off |=> module_active [*2])
      else $error("module went idle too early");
   a_drain_ends: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      s_switch_off and !wr_mctl |-> ##[1:20] !module_active)
      else $error("shutdown never completed");
   a_accept_route: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      do_accept |=> accept_o.valid && cfg_q[accept_o.filter].enable)
      else $error("accept from disabled filter");

   ////////////////////////////////////////////////////////////////////////////
   // field placement and read path checks
   a_fc7_readback: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      rd_i && addr_i == IDX_FILTER_CONTROL_7 |=> rdata_o[31:24] == $past(cfg_q[7]))
      else $error("filter 31 byte misplaced on read");

   a_fc6_readback: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      rd_i && addr_i == IDX_FILTER_CONTROL_6 |=> rdata_o[15:8] == $past(cfg_q[1]))
      else $error("filter 25 byte misplaced on read");

   a_fc6_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      rd_i && addr_i == IDX_FILTER_CONTROL_6 |=> rdata_o[31:16] == 16'h0000)
      else $error("unused half of register 6 not zero");

   a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      rd_i && addr_i inside {4'h5, 4'h6, 4'h7} |=> rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_fc7_f28_fifo: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc7 && !cfg_q[4].enable |=> cfg_q[4].fifo_select == $past(wdata_i[4:0]))
      else $error("filter 28 fifo field misplaced");

   a_fc7_f31_fifo: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc7 && !cfg_q[7].enable |=> cfg_q[7].fifo_select == $past(wdata_i[28:24]))
      else $error("filter 31 fifo field misplaced");

   a_fc7_f30_mask: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc7 && !cfg_q[6].enable |=> cfg_q[6].mask_select == $past(wdata_i[22:21]))
      else $error("filter 30 mask field misplaced");

   a_fc7_f29_mask: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc7 && !cfg_q[5].enable |=> cfg_q[5].mask_select == $past(wdata_i[14:13]))
      else $error("filter 29 mask field misplaced");

   a_fc6_f25_mask: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc6 && !cfg_q[1].enable |=> cfg_q[1].mask_select == $past(wdata_i[14:13]))
      else $error("filter 25 mask field misplaced");

   a_f24_enable: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_fc6 |=> cfg_q[0].enable == $past(wdata_i[7]))
      else $error("filter 24 enable not written");

   a_locked_f25: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      cfg_q[1].enable |=> $stable(cfg_q[1].fifo_select) && $stable(cfg_q[1].mask_select))
      else $error("filter 25 selector changed while enabled");

   a_gap_unused: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !cfg_q[2].enable && !cfg_q[3].enable)
      else $error("unimplemented filter became enabled");

   a_mask_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      wr_mask |=> mask_q[$past(addr_i[1:0])] == $past(wdata_i[28:0]))
      else $error("acceptance mask not written");

   ////////////////////////////////////////////////////////////////////////////
   // acceptance, status and shutdown checks
   a_off_no_accept: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !on_q |=> !accept_o.valid)
      else $error("accept while module off");

   a_no_hit_quiet: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      rx_i.valid && !hit_any |=> !accept_o.valid)
      else $error("accept without a matching filter");

   a_accept_fifo: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      do_accept |=> accept_o.fifo == $past(cfg_q[hit_idx].fifo_select))
      else $error("accepted message sent to wrong fifo");

   a_match_flag: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      do_accept |=> stat_q[INT_MATCH_BIT])
      else $error("match status not set");

   a_syserr_set: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      sys_err_i && on_q |=> stat_q[INT_SYSERR_BIT])
      else $error("system error not latched");

   a_syserr_clear: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      off_on_edge |=> !stat_q[INT_SYSERR_BIT])
      else $error("system error kept after off-on");

   a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      irq_o == |(stat_q & imask_q))
      else $error("interrupt level disagrees with status");

   a_active_read: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      rd_i && addr_i == IDX_MODULE_CONTROL |=> rdata_o[MCTL_ACTIVE_BIT] == $past(module_active))
      else $error("module-active bit misread");

   a_off_stays: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      state_q == ST_OFF && !on_q |=> state_q == ST_OFF)
      else $error("module woke without being switched on");

endmodule : can_acceptance_filter_control

`default_nettype wire

//--- can_filter_pkg.sv
package can_filter_pkg;

   // register indices; the byte address is four times the index
   localparam logic [3:0] IDX_FILTER_CONTROL_6 = 4'h0;
   localparam logic [3:0] IDX_FILTER_CONTROL_7 = 4'h1;
   localparam logic [3:0] IDX_MODULE_CONTROL = 4'h2;
   localparam logic [3:0] IDX_INT_STATUS = 4'h3;
   localparam logic [3:0] IDX_INT_MASK = 4'h4;
   localparam logic [3:0] IDX_MASK_BASE = 4'h8;
   localparam logic [3:0] IDX_ID_BASE = 4'hC;

   // per-filter byte layout
   localparam int FLD_ENABLE = 7;
   localparam int FLD_MASK_SELECT_LO = 5;
   localparam int FLD_FIFO_SELECT_LO = 0;
   localparam int FILTER_FIRST = 24;

   // module control and interrupt bit positions
   localparam int MCTL_ON_BIT = 15;
   localparam int MCTL_ACTIVE_BIT = 11;
   localparam int INT_SYSERR_BIT = 0;
   localparam int INT_MATCH_BIT = 1;
   localparam int INT_NUM = 2;

   localparam logic [31:0] FILTER_CONTROL_RESET = 32'h0000_0000;
   localparam logic [28:0] ID_RESET = 29'h0000_0000;

   // cycles the module stays active after being switched off
   localparam int SHUTDOWN_CYCLES = 4;

   typedef struct packed {
      logic enable;
      logic [1:0] mask_select;
      logic [4:0] fifo_select;
   } filter_cfg_t;

   typedef struct packed {
      logic valid;
      logic [28:0] ident;
   } rx_ident_t;

   typedef struct packed {
      logic valid;
      logic [4:0] fifo;
      logic [2:0] filter;
   } accept_t;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_ON = 2'b01,
      ST_DRAIN = 2'b10
   } run_state_t;

endpackage : can_filter_pkg

//--- rx_partner.sv
`timescale 1ns/10ps
`default_nettype none
module rx_partner
   import can_filter_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic send_i,
   input wire logic [28:0] ident_i,
   input wire logic err_i,
   output rx_ident_t rx_o,
   output logic err_o
);
   initial begin
      rx_o = '0;
      err_o = 1'b0;
   end
   // idle ident flips every cycle so stale data never passes for valid
   always @(posedge ref_clk_i) begin
      rx_o.valid <= send_i;
      rx_o.ident <= send_i ? ident_i : ~rx_o.ident;
      err_o <= err_i;
   end
endmodule : rx_partner
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import can_filter_pkg::*;
;
   logic ref_clk_i = 0, arst_n_i = 0, wr = 0, rd = 0, snd = 0, err = 0, rd_seen = 0;
   logic [3:0] addr = '0;
   logic [31:0] wdata = '0, last_rd = '0, v, w, o, m;
   logic [28:0] sid = '0;
   logic [4:0] fs;
   logic sys_err, irq;
   logic [31:0] rdata;
   rx_ident_t rx;
   accept_t acc;
   logic [31:0] exp_q[$], msk_q[$];
   accept_t acc_q[$];
   int err_count = 0, compares = 0;

   always #2.5 ref_clk_i = ~ref_clk_i;

   can_acceptance_filter_control #(.NUM_FILTERS(8), .SHUTDOWN_LEN(4)) i_dut (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_i(rx), .sys_err_i(sys_err),
      .accept_o(acc), .irq_o(irq));
   rx_partner i_far (.ref_clk_i(ref_clk_i), .send_i(snd), .ident_i(sid), .err_i(err),
      .rx_o(rx), .err_o(sys_err));

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (err_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] got, exp, msk);
      compares++;
      if ((got & msk) !== (exp & msk)) begin
         err_count++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_acc(input accept_t got, exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t accept %h expected %h", $time, got, exp);
      end
   endtask : check_acc

   // strobes stay up until idle, so back-to-back cycles need no gap
   task automatic bus(input logic w_, r_, input logic [3:0] a, input logic [31:0] d);
      wr <= w_;
      rd <= r_;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
   endtask : bus

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, mk);
      exp_q.push_back(e);
      msk_q.push_back(mk);
      bus(1'b0, 1'b1, a, 32'h0);
   endtask : rd_reg

   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
   endtask : idle

   task automatic send(input logic s, input logic [28:0] id, input logic e, input accept_t x);
      if (x.valid) acc_q.push_back(x);
      snd <= s;
      sid <= id;
      err <= e;
      @(posedge ref_clk_i);
      snd <= 1'b0;
      err <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask : send

   // an enabled byte keeps its selectors whatever is written
   function automatic logic [31:0] lock(input logic [31:0] old, nw);
      logic [31:0] r;
      r = nw;
      for (int i = 0; i < 4; i++) if (old[8*i+7]) r[8*i+:7] = old[8*i+:7];
      return r;
   endfunction : lock

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk_i) begin
      rd_seen <= rd;
      if (rd_seen) begin
         last_rd = rdata;
         o = exp_q.pop_front();
         m = msk_q.pop_front();
         if (m != 0) check(rdata, o, m);
      end
      if (acc.valid !== 1'b0) begin
         if (acc_q.size() == 0) check_acc(acc, '0);
         else check_acc(acc, acc_q.pop_front());
      end
   end

   initial begin
      repeat (5000) @(posedge ref_clk_i);
      err_count++;
      print_verdict;
   end

   initial begin
      void'($urandom(32'hA0DD));
      repeat (8) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_reg(IDX_FILTER_CONTROL_6, FILTER_CONTROL_RESET, '1);
      rd_reg(IDX_FILTER_CONTROL_7, FILTER_CONTROL_RESET, '1);
      rd_reg(4'h5, 32'h0, '1);
      for (int k = 0; k < 4; k++) begin
         v = $urandom;
         w = $urandom;
         wr_reg(IDX_FILTER_CONTROL_6, 32'h0);
         wr_reg(IDX_FILTER_CONTROL_7, 32'h0);
         wr_reg(IDX_FILTER_CONTROL_7, v);
         rd_reg(IDX_FILTER_CONTROL_7, v, '1);
         wr_reg(IDX_FILTER_CONTROL_7, w);
         rd_reg(IDX_FILTER_CONTROL_7, lock(v, w), '1);
         wr_reg(IDX_FILTER_CONTROL_6, v);
         rd_reg(IDX_FILTER_CONTROL_6, v & 32'hFFFF, '1);
         wr_reg(IDX_FILTER_CONTROL_6, w);
         rd_reg(IDX_FILTER_CONTROL_6, lock(v & 32'hFFFF, w) & 32'hFFFF, '1);
      end
      wr_reg(IDX_FILTER_CONTROL_6, 32'h0);
      wr_reg(IDX_FILTER_CONTROL_7, 32'h0);
      wr_reg(IDX_MODULE_CONTROL, 32'h1 << MCTL_ON_BIT);
      wr_reg(IDX_INT_MASK, 32'h1 << INT_MATCH_BIT);
      wr_reg(IDX_ID_BASE, 32'h0);
      // each mask ignores one ident bit, so only the chosen mask lets it through
      for (int n = 0; n < 4; n++) begin
         fs = 5'($urandom);
         wr_reg(IDX_FILTER_CONTROL_6, 32'h0);
         wr_reg(4'(IDX_MASK_BASE + n), ~(32'h1 << n));
         wr_reg(IDX_FILTER_CONTROL_6, {24'h0, 1'b1, 2'(n), fs});
         idle(1);
         send(1'b1, 29'h1 << n, 1'b0, '{valid: 1'b1, fifo: fs, filter: 3'h0});
         send(1'b1, 29'h1 << ((n + 1) % 4), 1'b0, '0);
      end
      check({31'h0, irq}, 32'h1, 32'h1);
      rd_reg(IDX_INT_STATUS, 32'h2, 32'h3);
      wr_reg(IDX_INT_STATUS, 32'h2);
      wr_reg(IDX_FILTER_CONTROL_6, 32'h0);
      idle(3);
      check({31'h0, irq}, 32'h0, 32'h1);
      send(1'b1, 29'h0, 1'b0, '0);
      wr_reg(IDX_INT_MASK, 32'h1 << INT_SYSERR_BIT);
      idle(1);
      send(1'b0, 29'h0, 1'b1, '0);
      check({31'h0, irq}, 32'h1, 32'h1);
      wr_reg(IDX_INT_STATUS, 32'h1);
      rd_reg(IDX_INT_STATUS, 32'h1, 32'h1);
      wr_reg(IDX_MODULE_CONTROL, 32'h0);
      rd_reg(IDX_MODULE_CONTROL, 32'h0800, 32'h8800);
      idle(2);
      for (int t = 0; t < 20 && last_rd[MCTL_ACTIVE_BIT] !== 1'b0; t++) begin
         rd_reg(IDX_MODULE_CONTROL, 32'h0, 32'h0);
         idle(2);
      end
      check(last_rd, 32'h0, 32'h0800);
      rd_reg(IDX_INT_STATUS, 32'h1, 32'h1);
      wr_reg(IDX_MODULE_CONTROL, 32'h1 << MCTL_ON_BIT);
      rd_reg(IDX_INT_STATUS, 32'h0, 32'h1);
      idle(3);
      check({31'h0, irq}, 32'h0, 32'h1);
      check(acc_q.size() + exp_q.size(), 32'h0, '1);
      print_verdict;
   end
endmodule : tb_top
`default_nettype wire
